/* File: common/asrc_pkg.sv */
// Purpose: Shared constants for the asynchronous 8K x 8 static memory controller
// Assumes: Controller clock of 20 MHz (50 ns period)
// Notes: Timing figures are in ns; cycle counts derive from them
package asrc_pkg;

    // ========================================
    // Geometry
    localparam int ADDR_W = 13;            // Word address width
    localparam int DATA_W = 8;             // Shared data width
    localparam int DEPTH = 8192;           // Words held by the memory

    // ========================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;     // Controller clock period
    localparam int ACCESS_NS = 85;         // Slowest grade access time
    localparam int WRITE_PULSE_NS = 65;    // Select low to end of write
    localparam int DATA_SETUP_NS = 35;     // Data valid to end of write
    localparam int RECOVER_NS = 50;        // Both strobes high between cycles
    // Least times round up to whole cycles
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;              // Width of the phase counter

    // ========================================
    // Controller states
    typedef enum logic [2:0] {
        ASRC_IDLE,
        ASRC_RD_SETUP,
        ASRC_RD_WAIT,
        ASRC_WR_SETUP,
        ASRC_WR_PULSE,
        ASRC_WR_HOLD,
        ASRC_RECOVER
    } asrc_state_t;

endpackage : asrc_pkg

/* File: hw/asrc_controller.sv */
// Purpose: Host controller driving an asynchronous 8K x 8 static memory by its pins
// Assumes: Request inputs synchronous to clk; memory pins run through pads outside
// Notes: One access at a time; req_ready low while busy
`timescale 1ns/1ns
module asrc_controller #(
    parameter int ADDR_WIDTH = asrc_pkg::ADDR_W,
    parameter int DATA_WIDTH = asrc_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_WIDTH-1:0] req_addr,
    input wire logic [DATA_WIDTH-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_WIDTH-1:0] rsp_rdata,
    output logic [ADDR_WIDTH-1:0] mem_addr,
    output logic select_low_n,
    output logic select_high,
    output logic write_strobe_n,
    output logic output_enable_n,
    input wire logic [DATA_WIDTH-1:0] shared_data_in,
    output logic [DATA_WIDTH-1:0] shared_data_out,
    output logic shared_data_oe
);
    import asrc_pkg::*;

    // ========================================
    // Elaboration check
    // Refuses widths the pins cannot serve and access or write counts the timer cannot hold
    if (ADDR_WIDTH != ADDR_W || DATA_WIDTH != DATA_W
        || ACCESS_CYC > (1 << CNT_W) || WRITE_CYC > (1 << CNT_W)) begin : g_bad_params
        $error("asrc_controller: parameters do not fit the 8K x 8 memory");
    end

    // ========================================
    // State
    asrc_state_t state_reg, state_next;
    logic [ADDR_WIDTH-1:0] addr_reg, addr_next;     // Address on the pins
    logic [DATA_WIDTH-1:0] wdata_reg, wdata_next;   // Write data on the pins
    logic sel_n_reg, sel_n_next;                    // Active-low select
    logic sel_h_reg, sel_h_next;                    // Active-high select
    logic we_n_reg, we_n_next;                      // Write strobe, active low
    logic oe_n_reg, oe_n_next;                      // Output enable, active low
    logic drive_reg, drive_next;                    // Our data drivers on
    logic ready_reg, ready_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [DATA_WIDTH-1:0] rdata_reg, rdata_next;

    // Phase timer
    logic tmr_load;
    logic [CNT_W-1:0] tmr_value;
    logic tmr_done;

    // Cycle counts sized for the counter
    localparam logic [CNT_W-1:0] ACC_LD = CNT_W'(ACCESS_CYC - 1);
    localparam logic [CNT_W-1:0] WR_LD = CNT_W'(WRITE_CYC - 1);
    localparam logic [CNT_W-1:0] REC_LD = CNT_W'(RECOVER_CYC - 1);

    asrc_wait_counter #(
        .WIDTH(CNT_W)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .load(tmr_load),
        .load_value(tmr_value),
        .done(tmr_done)
    );

    // ========================================
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        sel_n_next = sel_n_reg;
        sel_h_next = sel_h_reg;
        we_n_next = we_n_reg;
        oe_n_next = oe_n_reg;
        drive_next = drive_reg;
        ready_next = ready_reg;
        rsp_valid_next = 1'b0;
        rdata_next = rdata_reg;
        tmr_load = 1'b0;
        tmr_value = '0;
        case (state_reg)
            ASRC_IDLE: begin
                if (req_valid && ready_reg) begin
                    // address moves only now
                    // Both strobes are high here, so no write is open
                    addr_next = req_addr;
                    wdata_next = req_wdata;
                    ready_next = 1'b0;
                    state_next = req_write ? ASRC_WR_SETUP : ASRC_RD_SETUP;
                end
            end
            ASRC_RD_SETUP: begin
                // address fixed while selected
                // Each read makes its own select edge; no address-controlled reads
                // address before select
                // Address settled a cycle ago; select falls now
                // strobe stays high
                sel_n_next = 1'b0;
                sel_h_next = 1'b1;
                oe_n_next = 1'b0;
                we_n_next = 1'b1;
                tmr_load = 1'b1;
                tmr_value = ACC_LD;
                state_next = ASRC_RD_WAIT;
            end
            ASRC_RD_WAIT: begin
                if (tmr_done) begin
                    rdata_next = shared_data_in;
                    rsp_valid_next = 1'b1;
                    oe_n_next = 1'b1;
                    sel_n_next = 1'b1;
                    tmr_load = 1'b1;
                    tmr_value = REC_LD;
                    state_next = ASRC_RECOVER;
                end
            end
            ASRC_WR_SETUP: begin
                // strobe falls with select
                // Falling together keeps the memory's drivers off
                // both selects active
                sel_n_next = 1'b0;
                sel_h_next = 1'b1;
                we_n_next = 1'b0;
                oe_n_next = 1'b1;
                drive_next = 1'b1;
                tmr_load = 1'b1;
                tmr_value = WR_LD;
                state_next = ASRC_WR_PULSE;
            end
            ASRC_WR_PULSE: begin
                if (tmr_done) begin
                    // select and strobe rise together
                    // Data and address hold past this edge by one cycle
                    sel_n_next = 1'b1;
                    we_n_next = 1'b1;
                    state_next = ASRC_WR_HOLD;
                end
            end
            ASRC_WR_HOLD: begin
                drive_next = 1'b0;
                rsp_valid_next = 1'b1;
                tmr_load = 1'b1;
                tmr_value = REC_LD;
                state_next = ASRC_RECOVER;
            end
            ASRC_RECOVER: begin
                // idle lets memory sleep
                // Deselected gap; memory powers down on its own
                if (tmr_done) begin
                    ready_next = 1'b1;
                    state_next = ASRC_IDLE;
                end
            end
            default: begin
                state_next = ASRC_IDLE;
            end
        endcase
    end

    // Register only
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ASRC_IDLE;
            // address and data hold while a cut write closes
            // Clearing them on that edge would move the address with the write open
            if (sel_n_reg && we_n_reg) begin
                addr_reg <= '0;
                wdata_reg <= '0;
            end
            sel_n_reg <= 1'b1;
            sel_h_reg <= 1'b0;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            drive_reg <= 1'b0;
            ready_reg <= 1'b1;
            rsp_valid_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            sel_n_reg <= sel_n_next;
            sel_h_reg <= sel_h_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
            drive_reg <= drive_next;
            ready_reg <= ready_next;
            rsp_valid_reg <= rsp_valid_next;
            rdata_reg <= rdata_next;
        end
    end

    // ========================================
    // Outputs, all from flip-flops
    assign req_ready = ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rdata_reg;
    assign mem_addr = addr_reg;
    assign select_low_n = sel_n_reg;
    assign select_high = sel_h_reg;
    assign write_strobe_n = we_n_reg;
    assign output_enable_n = oe_n_reg;
    assign shared_data_out = wdata_reg;
    assign shared_data_oe = drive_reg;
endmodule : asrc_controller

/* File: hw/asrc_wait_counter.sv */
// Purpose: Down counter that times the access, write pulse and recovery phases of a memory cycle
// Assumes: Load and count are mutually exclusive per cycle by use
// Notes: done is high while the count is zero
`timescale 1ns/1ns
module asrc_wait_counter #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic done
);
    // ========================================
    // Count register
    logic [WIDTH-1:0] count_reg;   // Cycles left in the phase
    logic [WIDTH-1:0] count_next;

    // Next count: load wins, otherwise count down to zero
    always_comb begin
        count_next = count_reg;
        if (load) begin
            count_next = load_value;
        end else if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Register only
    always_ff @(posedge clk) begin
        if (reset) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign done = (count_reg == '0);
endmodule : asrc_wait_counter

/* File: testbench/asrc_monitor.sv */
// Purpose: Pin checks on the memory controller
// Assumes: One clock, synchronous reset
// Notes: Sees only top module ports
`timescale 1ns/1ns
module asrc_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic rsp_valid,
    input wire logic [asrc_pkg::ADDR_W-1:0] mem_addr,
    input wire logic select_low_n,
    input wire logic select_high,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [asrc_pkg::DATA_W-1:0] shared_data_out,
    input wire logic shared_data_oe
);
    import asrc_pkg::*;
    // ========================================
    // Clocking
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Write window open
    sequence s_wr_open;
        !select_low_n && !write_strobe_n;
    endsequence
    // Strobe low two cycles, then closed
    sequence s_pulse;
        !write_strobe_n [*2] ##1 write_strobe_n;
    endsequence
    // ========================================
    // Write cycle
    // write pulse length
    a_write_pulse_len: assert property ($fell(write_strobe_n) |-> s_pulse)
        else $error("write pulse length wrong");
    a_strobe_fall_order: assert property (
        $fell(write_strobe_n) |-> $past(select_low_n) && select_high)
        else $error("strobe fell after select");
    a_select_rise_first: assert property ($rose(write_strobe_n) |-> select_low_n)
        else $error("select still low at strobe rise");
    a_addr_hold_write: assert property (
        s_wr_open |=> select_low_n || write_strobe_n || $stable(mem_addr))
        else $error("address moved in write");
    a_data_hold_write: assert property (
        s_wr_open |-> shared_data_oe ##1 (write_strobe_n || $stable(shared_data_out)))
        else $error("write data not held");
    // ========================================
    // Read cycle
    // strobe high in reads
    a_read_no_strobe: assert property (!output_enable_n |-> write_strobe_n)
        else $error("strobe low in read");
    a_read_no_fight: assert property (!output_enable_n |-> !shared_data_oe)
        else $error("both sides drive data");
    a_read_selected: assert property (
        !output_enable_n |-> !select_low_n && select_high)
        else $error("enable without select");
    a_addr_before_sel: assert property ($fell(select_low_n) |-> $stable(mem_addr))
        else $error("address moved at select");
    a_read_answer: assert property ($fell(output_enable_n) |-> ##[1:3] rsp_valid)
        else $error("read answer late");
endmodule : asrc_monitor

bind asrc_controller asrc_monitor u_mon (.clk, .reset, .rsp_valid, .mem_addr, .select_low_n,
    .select_high, .write_strobe_n, .output_enable_n, .shared_data_out, .shared_data_oe);

/* File: testbench/asrc_sram_model.sv */
// Purpose: Behavioural 8K x 8 static memory
// Assumes: No clock; reacts to pin levels
// Notes: Released bus shows inverted data
`timescale 1ns/1ns
module asrc_sram_model #(
    parameter int ACC_DLY = 80,
    parameter int AUTO_SLEEP_DELAY = 85
) (
    input wire logic [asrc_pkg::ADDR_W-1:0] mem_addr,
    input wire logic select_low_n,
    input wire logic select_high,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [asrc_pkg::DATA_W-1:0] shared_data_out,
    input wire logic shared_data_oe,
    output logic [asrc_pkg::DATA_W-1:0] shared_data_in
);
    import asrc_pkg::*;
    logic [DATA_W-1:0] store [DEPTH];
    logic [DATA_W-1:0] mem_q; // Array word after access delay
    logic reading; // Enabled read
    logic read_late; // Read held past the access delay
    logic active_supply_state = 1'b0; // High while powered up
    int wake_count = 0; // Power-up triggers seen so far
    event wake_ev; // One power-up trigger
    // wake on select, strobe, address or data
    always @(negedge select_low_n) -> wake_ev;
    always @(negedge write_strobe_n) if (!select_low_n) -> wake_ev;
    always @(mem_addr) if (!select_low_n) -> wake_ev;
    always @(shared_data_out) if (!select_low_n && !write_strobe_n) -> wake_ev;
    always @(wake_ev) wake_count++;
    // sleep after a quiet delay
    // Extended: a trigger during the delay adds a further full delay once it ends
    initial begin : supply_timer
        int seen;
        forever begin
            @(wake_count);
            active_supply_state = 1'b1;
            do begin
                seen = wake_count;
                #(AUTO_SLEEP_DELAY);
            end while (wake_count != seen);
            active_supply_state = 1'b0;
        end
    end
    always @* begin
        if (!select_low_n && select_high && !write_strobe_n) begin
            store[mem_addr] = shared_data_out;
        end
    end
    assign reading = !select_low_n && select_high && write_strobe_n && !output_enable_n;
    assign #(ACC_DLY) mem_q = store[mem_addr];
    assign #(ACC_DLY) read_late = reading;
    // Inverted value when released, so a stale sample shows up
    assign shared_data_in = shared_data_oe ? shared_data_out
        : (reading && read_late) ? mem_q : ~mem_q;
endmodule : asrc_sram_model

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the memory controller
// Assumes: 20 MHz clock, inputs change 5 ns after rising edge
// Notes: Table rows first, then supply, refusal and reset cases
`timescale 1ns/1ns
module testbench;
    import asrc_pkg::*;
    typedef struct packed {logic w; logic [12:0] a; logic [7:0] d;} asrc_row_t;
    logic clk, reset, req_valid, req_write, req_ready, rsp_valid;
    logic select_low_n, select_high, write_strobe_n, output_enable_n, shared_data_oe;
    logic [12:0] req_addr, mem_addr;
    logic [7:0] req_wdata, rsp_rdata, shared_data_in, shared_data_out, q;
    int err_count = 0;
    int n_compared = 0;
    // Reads expect the data column; boundary addresses on purpose
    asrc_row_t rows [7] = '{'{1, 13'h0000, 8'ha5}, '{1, 13'h1fff, 8'h5a},
        '{0, 13'h1fff, 8'h5a}, '{0, 13'h0000, 8'ha5}, '{1, 13'h0001, 8'h00},
        '{0, 13'h0001, 8'h00}, '{0, 13'h1fff, 8'h5a}};
    asrc_controller uut (.clk, .reset, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .select_low_n, .select_high,
        .write_strobe_n, .output_enable_n, .shared_data_in, .shared_data_out, .shared_data_oe);
    asrc_sram_model mem (.mem_addr, .select_low_n, .select_high, .write_strobe_n,
        .output_enable_n, .shared_data_out, .shared_data_oe, .shared_data_in);
    // ========================================
    // Helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Bounded wait for ready, sampled settled
    task automatic wait_ready;
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #5;
            n++;
        end
    endtask : wait_ready
    task automatic do_op(input logic w, input logic [12:0] a, input logic [7:0] d,
        output logic [7:0] r);
        int n;
        wait_ready();
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(posedge clk);
        #5;
        req_valid = 0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            #5;
            n++;
        end
        chk("response", 8'h01, {7'h00, rsp_valid});
        r = rsp_rdata;
    endtask : do_op
    task end_sim;
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    // ========================================
    // Clock, watchdog, sequence
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    initial begin
        #50000;
        err_count++;
        end_sim();
    end
    initial begin
        reset = 1;
        req_valid = 0;
        req_write = 0;
        req_addr = '0;
        req_wdata = '0;
        repeat (12) @(posedge clk);
        #5;
        reset = 0;
        chk("idle pins", 8'h1d, {2'h0, select_high, select_low_n, write_strobe_n,
            output_enable_n, shared_data_oe, req_ready});
        foreach (rows[i]) begin
            do_op(rows[i].w, rows[i].a, rows[i].d, q);
            if (!rows[i].w) chk("read data", rows[i].d, q);
        end
        // Memory wakes at the select fall and sleeps 85 ns later, while the read still holds select low
        wait_ready();
        req_valid = 1;
        req_write = 0;
        req_addr = 13'h0001;
        @(posedge clk);
        #5;
        req_valid = 0;
        @(posedge clk);
        #5;
        chk("supply awake", 8'h01, {7'h00, mem.active_supply_state});
        repeat (4) @(posedge clk);
        #5;
        chk("supply asleep", 8'h00, {7'h00, mem.active_supply_state});
        // Request held while busy must be ignored
        wait_ready();
        req_valid = 1;
        req_write = 1;
        req_addr = 13'h0003;
        req_wdata = 8'h11;
        @(posedge clk);
        #5;
        req_wdata = 8'h99;
        repeat (2) @(posedge clk);
        #5;
        req_valid = 0;
        do_op(0, 13'h0003, 8'h00, q);
        chk("refused write", 8'h11, q);
        // Reset in mid-pulse closes the write at once
        wait_ready();
        req_valid = 1;
        req_write = 1;
        req_addr = 13'h0004;
        req_wdata = 8'h77;
        @(posedge clk);
        #5;
        req_valid = 0;
        @(posedge clk);
        #5;
        chk("write open", 8'h00, {7'h00, write_strobe_n});
        reset = 1;
        @(posedge clk);
        #5;
        reset = 0;
        chk("pins after reset", 8'h1d, {2'h0, select_high, select_low_n, write_strobe_n,
            output_enable_n, shared_data_oe, req_ready});
        do_op(0, 13'h0000, 8'h00, q);
        chk("read after reset", 8'ha5, q);
        end_sim();
    end
endmodule : testbench
